// ---- dcu_dual_uart.sv ----
// Dual-channel serial transceiver with 64-entry FIFOs, AHB-Lite slave.
// Assumes one clock ref_clk for bus and core; serial pins are asynchronous.
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`default_nettype none
`include "dcu_cfg.svh"

////////////////////////////////////////////////////////////////////////////
module dcu_channel import dcu_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire dcu_req_s req,
    output logic [31:0] rdata,
    output logic tx_ready,
    output logic rx_ready,
    input wire dcu_ser_in_s ser_i,
    output dcu_ser_out_s ser_o,
    output logic irq,
    output logic rx_dma,
    output logic tx_dma
);
    dcu_ch_s s_q, s_d;
    logic [7:0] rx_mem [`DCU_DEPTH];
    logic [7:0] tx_mem [`DCU_DEPTH];
    logic rx_push, tx_push;
    logic [7:0] rx_wd;
    logic [`DCU_AW:0] rxc, txc;
    logic [1:0] wlen;
    logic [3:0] nb;
    logic [3:0] id;
    logic rx_hi, rx_lo, rxin, sleeping;
    logic [7:0] ch, mask, tch;
    logic [4:0] stop_last;

    assign rxc = s_q.rx_wp - s_q.rx_rp;
    assign txc = s_q.tx_wp - s_q.tx_rp;
    assign wlen = s_q.line[1:0];
    assign nb = {2'b01, wlen};
    assign mask = 8'hff >> ~wlen;
    assign rx_hi = rxc >= {1'b0, s_q.halt};
    assign rx_lo = rxc <= {1'b0, s_q.resume};
    // Loop-back feeds the transmitter output to the receiver in place of rxd; the txd pin still carries it
    assign rxin = s_q.line[`DCU_LN_LOOP] ? s_q.txo : s_q.rx_sync[1];
    assign sleeping = s_q.line[`DCU_LN_SLEEP] && s_q.tst == TX_IDLE &&
        s_q.rst == RX_IDLE && txc == '0 && rxin;
    assign ch = s_q.rsh >> ~wlen;
    assign stop_last = !s_q.line[`DCU_LN_STOP2] ? `DCU_STOP1 :
        (wlen == 2'd0 ? `DCU_STOP15 : `DCU_STOP2);

    always_comb begin
        s_d = s_q;
        rx_push = 1'b0;
        tx_push = 1'b0;
        rx_wd = 8'h00;
        tch = 8'h00;
        s_d.rx_sync = {s_q.rx_sync[0], ser_i.rxd};
        s_d.cts_sync = {s_q.cts_sync[0], ser_i.cts_n};
        s_d.cd_sync = {s_q.cd_sync[0], ser_i.cd_n};
        // Host writes first so hardware sets below win over clears
        if (req.wr) begin
            unique case (req.wr_off)
                `DCU_OFF_DATA: if (!txc[`DCU_AW]) begin
                    tx_push = 1'b1;
                    s_d.tx_wp = s_q.tx_wp + 1'b1;
                end
                `DCU_OFF_LINE: s_d.line = req.wdata[7:0];
                `DCU_OFF_DIV: begin
                    s_d.div = req.wdata[15:0];
                    s_d.pre4 = req.wdata[`DCU_DIV_PRE4];
                end
                `DCU_OFF_FLOW: s_d.flow = req.wdata[23:0];
                `DCU_OFF_TRIG: begin
                    s_d.rx_trig = req.wdata[5:0];
                    s_d.tx_trig = req.wdata[13:8];
                    s_d.ien = req.wdata[19:16];
                end
                `DCU_OFF_THR: begin
                    s_d.halt = req.wdata[5:0];
                    s_d.resume = req.wdata[13:8];
                end
                `DCU_OFF_STAT: begin
                    s_d.ovr = s_q.ovr & ~req.wdata[3];
                    s_d.perr = s_q.perr & ~req.wdata[4];
                    s_d.ferr = s_q.ferr & ~req.wdata[5];
                    s_d.brk = s_q.brk & ~req.wdata[6];
                    s_d.idle = s_q.idle & ~req.wdata[7];
                    s_d.udr = s_q.udr & ~req.wdata[8];
                end
                default: ;
            endcase
        end
        if (req.rd && req.rd_off == `DCU_OFF_DATA && rxc != '0) begin
            s_d.rx_rp = s_q.rx_rp + 1'b1;
        end
        //////////////////////////////////////////////////////////////////
        // Sixteen-times bit clock; divisor zero behaves as one
        s_d.tick = 1'b0;
        if (!sleeping) begin
            s_d.pre = s_q.pre + 2'd1;
            if (!s_q.pre4 || s_q.pre == 2'd3) begin
                if ({1'b0, s_q.bcnt} + 17'h1 >= {1'b0, s_q.div}) begin
                    s_d.bcnt = 16'h0000;
                    s_d.tick = 1'b1;
                end else begin
                    s_d.bcnt = s_q.bcnt + 16'h0001;
                end
            end
        end
        //////////////////////////////////////////////////////////////////
        if (s_q.tick) begin
            s_d.rcnt = s_q.rcnt + 5'h01;
            unique case (s_q.rst)
                RX_IDLE: begin
                    s_d.rcnt = 5'h00;
                    if (!rxin) begin
                        s_d.rst = RX_START;
                        s_d.icnt = 10'h000;
                    end else if (s_q.idle_arm) begin
                        s_d.icnt = s_q.icnt + 10'h001;
                        if (s_q.icnt == `DCU_IDLE_TICKS) begin
                            s_d.idle = 1'b1;
                            s_d.idle_arm = 1'b0;
                        end
                    end
                end
                RX_START: if (s_q.rcnt == `DCU_MID) begin
                    s_d.rcnt = 5'h00;
                    s_d.rbit = 4'h0;
                    s_d.rpar = 1'b0;
                    s_d.rany = 1'b0;
                    // Glitch shorter than half a bit is dropped
                    s_d.rst = rxin ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (s_q.rcnt == `DCU_LAST) begin
                    s_d.rcnt = 5'h00;
                    s_d.rsh = {rxin, s_q.rsh[7:1]};
                    s_d.rpar = s_q.rpar ^ rxin;
                    s_d.rany = s_q.rany | rxin;
                    s_d.rbit = s_q.rbit + 4'h1;
                    if (s_q.rbit == nb) begin
                        s_d.rst = s_q.line[`DCU_LN_PEN] ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: if (s_q.rcnt == `DCU_LAST) begin
                    s_d.rcnt = 5'h00;
                    s_d.rany = s_q.rany | rxin;
                    if (s_q.rpar ^ rxin ^ ~s_q.line[`DCU_LN_EVEN]) begin
                        s_d.perr = 1'b1;
                    end
                    s_d.rst = RX_STOP;
                end
                RX_STOP: if (s_q.rcnt == `DCU_LAST) begin
                    s_d.idle_arm = 1'b1;
                    if (!rxin) begin
                        s_d.ferr = 1'b1;
                    end
                    if (!rxin && !s_q.rany) begin
                        s_d.brk = 1'b1;
                    end
                    if (s_q.flow[`DCU_FL_SWF] && ch == s_q.flow[23:16]) begin
                        s_d.xoff_rcvd = 1'b1;
                    end else if (s_q.flow[`DCU_FL_SWF] &&
                            ch == s_q.flow[15:8]) begin
                        s_d.xoff_rcvd = 1'b0;
                    end else begin
                        if (s_q.flow[`DCU_FL_XANY]) begin
                            s_d.xoff_rcvd = 1'b0;
                        end
                        if (rxc[`DCU_AW]) begin
                            s_d.ovr = 1'b1;
                        end else begin
                            rx_push = 1'b1;
                            rx_wd = ch;
                            s_d.rx_wp = s_q.rx_wp + 1'b1;
                        end
                    end
                    s_d.rst = rxin ? RX_IDLE : RX_WAIT;
                end
                RX_WAIT: if (rxin) begin
                    s_d.rst = RX_IDLE;
                end
                default: s_d.rst = RX_IDLE;
            endcase
        end
        //////////////////////////////////////////////////////////////////
        if (s_q.tick) begin
            s_d.tcnt = s_q.tcnt + 5'h01;
            unique case (s_q.tst)
                TX_IDLE: begin
                    s_d.tcnt = 5'h00;
                    if (s_q.flow[`DCU_FL_SWF] && rx_hi && !s_q.xoff_sent) begin
                        tch = s_q.flow[23:16];
                        s_d.xoff_sent = 1'b1;
                        s_d.tst = TX_START;
                    end else if (s_q.flow[`DCU_FL_SWF] && s_q.xoff_sent &&
                            rx_lo) begin
                        tch = s_q.flow[15:8];
                        s_d.xoff_sent = 1'b0;
                        s_d.tst = TX_START;
                    end else if (txc != '0 && !s_q.xoff_rcvd &&
                            !(s_q.flow[`DCU_FL_ACTS] && s_q.cts_sync[1])) begin
                        tch = tx_mem[s_q.tx_rp[`DCU_AW-1:0]];
                        s_d.tx_rp = s_q.tx_rp + 1'b1;
                        s_d.udr_arm = 1'b1;
                        s_d.tst = TX_START;
                    end else if (s_q.udr_arm && txc == '0) begin
                        s_d.udr = 1'b1;
                        s_d.udr_arm = 1'b0;
                    end
                    if (s_d.tst == TX_START) begin
                        s_d.tsh = tch;
                        s_d.tpar = ^(tch & mask) ^ ~s_q.line[`DCU_LN_EVEN];
                        s_d.txd = 1'b0;
                    end
                end
                TX_START: if (s_q.tcnt == `DCU_LAST) begin
                    s_d.tcnt = 5'h00;
                    s_d.tbit = 4'h0;
                    s_d.txd = s_q.tsh[0];
                    s_d.tst = TX_DATA;
                end
                TX_DATA: if (s_q.tcnt == `DCU_LAST) begin
                    s_d.tcnt = 5'h00;
                    s_d.tbit = s_q.tbit + 4'h1;
                    s_d.tsh = {1'b0, s_q.tsh[7:1]};
                    s_d.txd = s_q.tsh[1];
                    if (s_q.tbit == nb) begin
                        s_d.tst = s_q.line[`DCU_LN_PEN] ? TX_PAR : TX_STOP;
                        s_d.txd = s_q.line[`DCU_LN_PEN] ? s_q.tpar : 1'b1;
                    end
                end
                TX_PAR: if (s_q.tcnt == `DCU_LAST) begin
                    s_d.tcnt = 5'h00;
                    s_d.txd = 1'b1;
                    s_d.tst = TX_STOP;
                end
                TX_STOP: if (s_q.tcnt == stop_last) begin
                    s_d.tst = TX_IDLE;
                end
                default: s_d.tst = TX_IDLE;
            endcase
        end
        // Hysteresis between halt and resume avoids RTS chatter
        if (rx_hi) begin
            s_d.rts_n = 1'b1;
        end else if (rx_lo) begin
            s_d.rts_n = 1'b0;
        end
        s_d.txo = s_d.txd & ~s_d.line[`DCU_LN_BRK];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.div <= `DCU_RST_DIV;
            s_q.halt <= `DCU_RST_HALT;
            s_q.resume <= `DCU_RST_RESUME;
            s_q.flow <= {`DCU_RST_XOFF, `DCU_RST_XON, 8'h00};
            s_q.rts_n <= 1'b1;
            s_q.rx_sync <= 2'b11;
            s_q.cts_sync <= 2'b11;
            s_q.cd_sync <= 2'b11;
            s_q.rst <= RX_IDLE;
            s_q.tst <= TX_IDLE;
            s_q.txd <= 1'b1;
            s_q.txo <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rx_push) begin
            rx_mem[s_q.rx_wp[`DCU_AW-1:0]] <= rx_wd;
        end
        if (tx_push) begin
            tx_mem[s_q.tx_wp[`DCU_AW-1:0]] <= req.wdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        // Lower code wins: errors, then receive level, transmit, underflow
        id = 4'h0;
        if (s_q.ien[3] && s_q.udr) id = 4'h4;
        if (s_q.ien[2] && txc <= {1'b0, s_q.tx_trig}) id = 4'h3;
        if (s_q.ien[1] && rx_dma) id = 4'h2;
        if (s_q.ien[0] && (s_q.ovr | s_q.perr | s_q.ferr | s_q.brk)) begin
            id = 4'h1;
        end
        rdata = 32'h0000_0000;
        unique case (req.rd_off)
            `DCU_OFF_DATA: rdata = {24'h000000,
                rx_mem[s_q.rx_rp[`DCU_AW-1:0]]};
            `DCU_OFF_LINE: rdata = {24'h000000, s_q.line};
            `DCU_OFF_DIV: rdata = {15'h0000, s_q.pre4, s_q.div};
            `DCU_OFF_FLOW: rdata = {8'h00, s_q.flow};
            `DCU_OFF_TRIG: rdata = {12'h000, s_q.ien, 2'b00, s_q.tx_trig,
                2'b00, s_q.rx_trig};
            `DCU_OFF_THR: rdata = {18'h00000, s_q.resume, 2'b00, s_q.halt};
            `DCU_OFF_STAT: rdata = {16'h0000, id, 2'b00, s_q.xoff_rcvd,
                s_q.udr, s_q.idle, s_q.brk, s_q.ferr, s_q.perr, s_q.ovr,
                txc == '0 && s_q.tst == TX_IDLE, tx_ready, rx_ready};
            `DCU_OFF_MSR: rdata = {29'h00000000, ~ser_o.rts_n,
                ~s_q.cts_sync[1], ~s_q.cd_sync[1]};
            `DCU_OFF_LVL: rdata = {9'h000, rxc, 9'h000, txc};
            default: rdata = 32'h0000_0000;
        endcase
    end

    assign rx_ready = rxc != '0;
    assign tx_ready = !txc[`DCU_AW];
    assign rx_dma = rxc != '0 && rxc >= {1'b0, s_q.rx_trig};
    assign tx_dma = txc <= {1'b0, s_q.tx_trig};
    assign irq = id != 4'h0;
    assign ser_o.txd = s_q.txo;
    assign ser_o.rts_n = s_q.flow[`DCU_FL_ARTS] ? s_q.rts_n :
        ~s_q.flow[`DCU_FL_RTS];
endmodule

////////////////////////////////////////////////////////////////////////////
module dcu_dual_uart import dcu_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [`DCU_NCH-1:0] ser_rxd,
    input wire logic [`DCU_NCH-1:0] cts_n,
    input wire logic [`DCU_NCH-1:0] carrier_detect_n,
    output logic [`DCU_NCH-1:0] ser_txd,
    output logic [`DCU_NCH-1:0] rts_n,
    output logic [`DCU_NCH-1:0] ch_irq,
    output logic [`DCU_NCH-1:0] rx_dma_req,
    output logic [`DCU_NCH-1:0] tx_dma_req
);
    dcu_top_s s_q, s_d;
    dcu_req_s req [`DCU_NCH];
    logic [31:0] ch_rdata [`DCU_NCH];
    logic [`DCU_NCH-1:0] tx_ready_flag, rx_ready_flag;
    logic acc, stall, map;

    // A read right behind a write waits one cycle so it sees the new value
    assign stall = s_q.wr_pend & hsel & htrans[1] & ~hwrite;
    assign acc = hsel & htrans[1] & hready;
    assign map = haddr[31:8] == 24'h000000 && hsize == 3'b010;
    assign hreadyout = ~stall;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;

    generate
        for (genvar i = 0; i < `DCU_NCH; i++) begin : g_ch
            // Channel takes part only when its address bit selects it
            assign req[i].wr = s_q.wr_pend && s_q.wr_map &&
                s_q.wr_ch == 1'(i);
            assign req[i].rd = acc && !hwrite && map &&
                !haddr[`DCU_SUM_BIT] && haddr[`DCU_CH_BIT] == 1'(i);
            assign req[i].wr_off = s_q.wr_off;
            assign req[i].rd_off = haddr[5:0];
            assign req[i].wdata = hwdata;
            dcu_channel u_ch (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .req(req[i]),
                .rdata(ch_rdata[i]),
                .tx_ready(tx_ready_flag[i]),
                .rx_ready(rx_ready_flag[i]),
                .ser_i({ser_rxd[i], cts_n[i], carrier_detect_n[i]}),
                .ser_o({ser_txd[i], rts_n[i]}),
                .irq(ch_irq[i]),
                .rx_dma(rx_dma_req[i]),
                .tx_dma(tx_dma_req[i])
            );
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        s_d.wr_pend = 1'b0;
        if (acc && hwrite) begin
            s_d.wr_pend = 1'b1;
            s_d.wr_map = map && !haddr[`DCU_SUM_BIT];
            s_d.wr_ch = haddr[`DCU_CH_BIT];
            s_d.wr_off = haddr[5:0];
        end
        if (acc && !hwrite) begin
            s_d.rdata = 32'h0000_0000;
            if (map && haddr[`DCU_SUM_BIT] && haddr[6:0] == 7'h00) begin
                s_d.rdata = 32'({rx_ready_flag, tx_ready_flag});
            end else if (map && !haddr[`DCU_SUM_BIT]) begin
                s_d.rdata = ch_rdata[haddr[`DCU_CH_BIT]];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// ---- dcu_cfg.svh ----
// Constants of the dual-channel serial transceiver: offsets, fields, resets.
// Assumes inclusion by bare name from the package.
`ifndef DCU_CFG_SVH
`define DCU_CFG_SVH
`define DCU_NCH 2
`define DCU_AW 6
`define DCU_DEPTH 64
`define DCU_CH_BIT 6
`define DCU_SUM_BIT 7
`define DCU_OFF_DATA 6'h00
`define DCU_OFF_LINE 6'h04
`define DCU_OFF_DIV 6'h08
`define DCU_OFF_FLOW 6'h0c
`define DCU_OFF_TRIG 6'h10
`define DCU_OFF_THR 6'h14
`define DCU_OFF_STAT 6'h18
`define DCU_OFF_MSR 6'h1c
`define DCU_OFF_LVL 6'h20
`define DCU_LN_STOP2 2
`define DCU_LN_PEN 3
`define DCU_LN_EVEN 4
`define DCU_LN_BRK 5
`define DCU_LN_LOOP 6
`define DCU_LN_SLEEP 7
`define DCU_FL_ARTS 0
`define DCU_FL_ACTS 1
`define DCU_FL_SWF 2
`define DCU_FL_XANY 3
`define DCU_FL_RTS 4
`define DCU_DIV_PRE4 16
`define DCU_RST_DIV 16'h0001
`define DCU_RST_HALT 6'h30
`define DCU_RST_RESUME 6'h10
`define DCU_RST_XON 8'h11
`define DCU_RST_XOFF 8'h13
`define DCU_MID 5'h07
`define DCU_LAST 5'h0f
`define DCU_STOP1 5'h0f
`define DCU_STOP15 5'h17
`define DCU_STOP2 5'h1f
`define DCU_IDLE_TICKS 10'h280
`endif

// ---- dcu_pkg.sv ----
// Types of the dual-channel serial transceiver.
// Assumes dcu_cfg.svh on the include path.
`default_nettype none
`include "dcu_cfg.svh"
package dcu_pkg;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP,
        RX_WAIT} dcu_rx_e;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR,
        TX_STOP} dcu_tx_e;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] wr_off;
        logic [5:0] rd_off;
        logic [31:0] wdata;
    } dcu_req_s;
    typedef struct packed {
        logic rxd;
        logic cts_n;
        logic cd_n;
    } dcu_ser_in_s;
    typedef struct packed {
        logic txd;
        logic rts_n;
    } dcu_ser_out_s;
    typedef struct packed {
        logic [7:0] line;
        logic [15:0] div;
        logic pre4;
        logic [23:0] flow;
        logic [3:0] ien;
        logic [5:0] rx_trig;
        logic [5:0] tx_trig;
        logic [5:0] halt;
        logic [5:0] resume;
        logic ovr, perr, ferr, brk, idle, udr, udr_arm, xoff_rcvd, xoff_sent;
        logic rts_n;
        logic [1:0] pre;
        logic [15:0] bcnt;
        logic tick;
        logic [1:0] rx_sync, cts_sync, cd_sync;
        dcu_rx_e rst;
        logic [4:0] rcnt;
        logic [3:0] rbit;
        logic [7:0] rsh;
        logic rpar, rany;
        logic [9:0] icnt;
        logic idle_arm;
        dcu_tx_e tst;
        logic [4:0] tcnt;
        logic [3:0] tbit;
        logic [7:0] tsh;
        logic tpar, txd, txo;
        logic [`DCU_AW:0] rx_wp, rx_rp, tx_wp, tx_rp;
    } dcu_ch_s;
    typedef struct packed {
        logic wr_pend;
        logic wr_map;
        logic wr_ch;
        logic [5:0] wr_off;
        logic [31:0] rdata;
    } dcu_top_s;
endpackage
`default_nettype wire

// ---- dcu_dual_uart_sva.sv ----
// Bus and serial-line checks for the dual-channel serial transceiver.
// Assumes hready is tied to hreadyout and channel 0 divisor starts at one.
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module dcu_dual_uart_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [1:0] carrier_detect_n,
    input wire logic [1:0] ser_txd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_take;
    logic rd_word;
    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    assign rd_word = rd_take && hsize == 3'b010;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    bus_okay_a: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    short_wait_a: assert property (!hreadyout |=> hreadyout)
        else $error("wait longer than one cycle");
    wait_cause_a: assert property (!hreadyout |-> htrans[1] && !hwrite)
        else $error("wait without pending read");
    size_zero_a: assert property (rd_take && hsize != 3'b010 |=>
        hrdata == 32'h0) else $error("narrow read not zero");
    high_zero_a: assert property (rd_take && haddr[31:8] != 24'h0 |=>
        hrdata == 32'h0) else $error("foreign address read not zero");
    gap_zero_a: assert property (rd_take && !haddr[7] &&
        haddr[5:0] >= 6'h24 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    summary_a: assert property (rd_word && haddr == 32'h80 |=>
        hrdata[31:4] == 28'h0) else $error("summary spare bits set");
    carrier_a: assert property (rd_word && haddr == 32'h1c &&
        !carrier_detect_n[0] && $past(!carrier_detect_n[0], 3) |=> hrdata[0])
        else $error("carrier not shown");
    start_len_a: assert property ($fell(ser_txd[0]) |->
        !ser_txd[0] [*8]) else $error("start bit too short");
    cover property (rd_word && haddr == 32'h80);
    cover property ($fell(ser_txd[0]));
    cover property (rd_take && hsize != 3'b010);
endmodule
////////////////////////////////////////////////////////////////////////////
bind dcu_dual_uart dcu_dual_uart_sva u_sva (.ref_clk, .rst_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hready, .hrdata, .hreadyout, .hresp,
    .carrier_detect_n, .ser_txd);
`default_nettype wire

// ---- dcu_line_partner.sv ----
// Modem-side model of one serial line: sends and captures characters.
// Assumes a bit time of BIT_NS, set to match divisor one at 8 ns clock.
`default_nettype none
module dcu_line_partner #(parameter int BIT_NS = 128) (
    input wire logic txd,
    output logic rxd,
    output logic cts_n,
    output logic cd_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rxd = 1'b1;
        cts_n = 1'b0;
        cd_n = 1'b1;
    end
    task automatic send(input logic [7:0] b);
        #1 rxd = 1'b0;
        #BIT_NS;
        for (int i = 0; i < 8; i++) begin
            rxd = b[i];
            #BIT_NS;
        end
        rxd = 1'b1;
        #BIT_NS;
    endtask
    // Samples at mid-bit, so parity lands in the bit after the data
    task automatic get(input int n, output logic [7:0] b);
        b = 8'h00;
        @(negedge txd);
        #(BIT_NS / 2);
        for (int i = 0; i < n; i++) begin
            #BIT_NS;
            b[i] = txd;
        end
    endtask
endmodule
`default_nettype wire

// ---- dcu_dual_uart_tb_top.sv ----
// Self-checking bench for the dual-channel serial transceiver.
// Assumes one AHB-Lite master here and a line model on channel 0.
`default_nettype none
module dcu_dual_uart_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0] htrans = '0, txd, rts, irq, rdq, tdq;
    logic [2:0] hsize = 3'b010;
    logic rxd0, cts0, cd0;
    int n_fail = 0, check_count = 0, cyc = 0;
    always #4 ref_clk = ~ref_clk;
    dcu_dual_uart dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ser_rxd({1'b1, rxd0}),
        .cts_n({1'b1, cts0}), .carrier_detect_n({1'b1, cd0}), .ser_txd(txd),
        .rts_n(rts), .ch_irq(irq), .rx_dma_req(rdq), .tx_dma_req(tdq));
    dcu_line_partner ln (.txd(txd[0]), .rxd(rxd0), .cts_n(cts0), .cd_n(cd0));
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, wd,
        output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rdc(input string nm, input logic [31:0] a, e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(nm, e, r);
    endtask
    // Polls status; the global cycle ceiling ends a stuck wait
    task automatic wait_stat(input logic [31:0] m);
        logic [31:0] r;
        r = '0;
        while ((r & m) !== m) bus(1'b0, 32'h18, 32'h0, r);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("tx_dma", 32'h1, {31'h0, tdq[0]});
        chk("rts_n", 32'h1, {31'h0, rts[0]});
        chk("txd_b", 32'h1, {31'h0, txd[1]});
        rdc("divisor", 32'h08, 32'h1);
        rdc("threshold", 32'h14, 32'h1030);
        rdc("flow", 32'h0c, 32'h131100);
        rdc("divisor_b", 32'h48, 32'h1);
    endtask
    task automatic t_refuse;
        rdc("gap", 32'h24, 32'h0);
        rdc("high", 32'h108, 32'h0);
        hsize <= 3'b000;
        wr(32'h08, 32'h5);
        rdc("narrow", 32'h08, 32'h0);
        hsize <= 3'b010;
        rdc("kept", 32'h08, 32'h1);
    endtask
    // Read address phase laid over a write data phase forces one wait
    task automatic t_stall;
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= 32'h10;
        htrans <= 2'b10;
        hwrite <= 1'b1;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hwrite <= 1'b0;
        hwdata <= 32'h0000_0305;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        chk("stall_rd", 32'h0000_0305, hrdata);
    endtask
    task automatic t_msr;
        ln.cd_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rdc("msr_on", 32'h1c, 32'h3);
        ln.cd_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rdc("msr_off", 32'h1c, 32'h2);
        rdc("msr_b", 32'h5c, 32'h0);
    endtask
    task automatic t_tx;
        logic [7:0] lines [2] = '{8'h03, 8'h1a};
        logic [7:0] dat [2] = '{8'ha5, 8'h31};
        logic [7:0] exp [2] = '{8'ha5, 8'hb1};
        logic [7:0] g;
        for (int i = 0; i < 2; i++) begin
            wr(32'h04, {24'h0, lines[i]});
            fork
                ln.get(8, g);
                wr(32'h00, {24'h0, dat[i]});
            join
            chk("tx_char", {24'h0, exp[i]}, {24'h0, g});
            wait_stat(32'h4);
        end
    endtask
    task automatic t_rx;
        logic [31:0] r;
        wr(32'h04, 32'h03);
        wr(32'h10, 32'h0002_0000);
        ln.send(8'h5c);
        wait_stat(32'h1);
        chk("rx_dma", 32'h1, {31'h0, rdq[0]});
        chk("irq", 32'h1, {31'h0, irq[0]});
        rdc("status", 32'h18, 32'h2107);
        rdc("summary", 32'h80, 32'h7);
        bus(1'b0, 32'h00, 32'h0, r);
        chk("rx_char", 32'h5c, {24'h0, r[7:0]});
        chk("rx_dma_off", 32'h0, {31'h0, rdq[0]});
        chk("irq_off", 32'h0, {31'h0, irq[0]});
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            complete_run;
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset;
        t_refuse;
        t_stall;
        t_msr;
        t_tx;
        t_rx;
        complete_run;
    end
endmodule
`default_nettype wire
